// file: hdl/ppp_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module ppp_fifo
  import ppp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r];

  // Storage is written only; it needs no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: hdl/ppp_host.sv
// Programmer that drives the parallel programming pins of the target device.
`timescale 1ns/1ps
module ppp_host
  import ppp_pkg::*;
#(
  parameter int ERASE_US_P = ERASE_US,
  parameter int CNT_W      = 24,
  parameter bit SKIP_FF    = 1'b1,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // User requests
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire ppp_req_t   req,
  output logic            done,
  output logic            refused,
  output logic            prog_mode,
  // Read data to user
  output logic            rd_valid,
  input  wire logic       rd_ready,
  output logic [7:0]      rd_data,
  // Device pins
  output logic            reset_hv,
  output logic            load_strobe,
  output logic            xtal_action_1,
  output logic            xtal_action_0,
  output logic            byte_select,
  output logic            write_strobe_n,
  output logic            output_enable_n,
  output logic [7:0]      data_o,
  output logic            data_oe_n,
  input  wire logic [7:0] data_i,
  input  wire logic       ready_busy_n
);
  localparam int ERASE_CYC = ERASE_US_P * CLK_MHZ;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_ENT_LO = 4'h1,
    S_ENT_HV = 4'h2,
    S_SETUP  = 4'h3,
    S_LOAD   = 4'h4,
    S_WR_LO  = 4'h5,
    S_WAIT_LO = 4'h6,
    S_WAIT_HI = 4'h7,
    S_RD     = 4'h8,
    S_PUSH   = 4'h9,
    S_GAP    = 4'hA
  } ppp_state_t;

  // Commands whose writes touch flash or EEPROM and so need a prior erase.
  function automatic logic is_mem_wr(input logic [7:0] c);
    return (c == CMD_FLASH_WR) || (c == CMD_EE_WR);
  endfunction

  // Commands whose write pulse gives no ready/busy activity.
  function automatic logic is_silent_wr(input logic [7:0] c);
    return (c == CMD_ERASE) || (c == CMD_FUSE_WR);
  endfunction

  ppp_state_t       state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [1:0]       act_r;
  logic             mode_r;
  logic             done_r;
  logic             refused_r;
  logic [7:0]       cmd_r;
  logic [7:0]       hi_last_r;
  logic             hi_ok_r;
  logic [7:0]       dlo_r;
  logic [7:0]       dhi_r;
  logic             erased_r;
  logic [7:0]       rd_byte_r;
  logic             fifo_in_ready;
  logic             accept;
  logic             skip_hi;
  logic             wr_bad;
  logic             wr_skip;
  logic [7:0]       pend_byte;
  logic             act_go;

  // ****************************************
  // Request decisions
  // ****************************************

  // A request is taken only in idle; the decisions below look at it then.
  assign req_ready = (state_r == S_IDLE);
  assign accept    = req_ready && req_valid;
  assign pend_byte = req.bs ? dhi_r : dlo_r;
  // Same high byte again means the same page, so the load is dropped.
  assign skip_hi   = (req.op == OP_ADDR) && req.bs && hi_ok_r
                     && ((req.data & ADDR_HI_MASK) == hi_last_r);
  assign wr_bad    = (req.op == OP_WRITE) && is_mem_wr(cmd_r) && !erased_r;
  assign wr_skip   = SKIP_FF && (req.op == OP_WRITE) && is_mem_wr(cmd_r)
                     && (pend_byte == ERASED_BYTE);
  // A request that really reaches the pins while in programming mode.
  assign act_go    = accept && mode_r && !skip_hi && !wr_bad && !wr_skip;

  assign done          = done_r;
  assign refused       = refused_r;
  assign prog_mode     = mode_r;
  assign xtal_action_1 = act_r[1];
  assign xtal_action_0 = act_r[0];

  // ****************************************
  // Pin sequencer
  // ****************************************

  // One state machine paces every pin; counts are loaded as cycles minus one, ending on zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r         <= S_IDLE;
      cnt_r           <= '0;
      mode_r          <= 1'b0;
      done_r          <= 1'b0;
      refused_r       <= 1'b0;
      reset_hv        <= 1'b0;
      load_strobe     <= 1'b0;
      act_r           <= ACT_IDLE;
      byte_select     <= 1'b0;
      write_strobe_n  <= 1'b1;
      output_enable_n <= 1'b1;
      data_o          <= '0;
      data_oe_n       <= 1'b1;
      rd_byte_r       <= '0;
    end else begin
      done_r    <= 1'b0;
      refused_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (accept) begin
            if (req.op == OP_ENTER) begin
              // Reset pin and byte_select low before the high voltage.
              reset_hv       <= 1'b0;
              byte_select    <= 1'b0;
              mode_r         <= 1'b0;
              act_r          <= ACT_IDLE;
              write_strobe_n <= 1'b1;
              data_oe_n      <= 1'b1;
              cnt_r          <= CNT_W'(SETUP_CYC - 1);
              state_r        <= S_ENT_LO;
            end else if (req.op == OP_EXIT) begin
              reset_hv  <= 1'b0;
              mode_r    <= 1'b0;
              data_oe_n <= 1'b1;
              done_r    <= 1'b1;
            end else if (!mode_r || wr_bad || req.op == OP_NOP) begin
              refused_r <= 1'b1;
              done_r    <= 1'b1;
            end else if (skip_hi || wr_skip) begin
              done_r <= 1'b1;
            end else if (req.op == OP_WRITE) begin
              // The latched command picks what the pulse does.
              byte_select    <= req.bs;
              data_oe_n      <= 1'b1;
              write_strobe_n <= 1'b0;
              cnt_r          <= (cmd_r == CMD_ERASE) ? CNT_W'(ERASE_CYC - 1)
                                                     : CNT_W'(STROBE_CYC - 1);
              state_r        <= S_WR_LO;
            end else if (req.op == OP_READ) begin
              // Release the bus in the same edge that hands it to the device.
              byte_select     <= req.bs;
              data_oe_n       <= 1'b1;
              output_enable_n <= 1'b0;
              cnt_r           <= CNT_W'(READ_CYC - 1);
              state_r         <= S_RD;
            end else begin
              // Command, address or data: set pins, then strobe.
              act_r     <= (req.op == OP_CMD)  ? ACT_CMD :
                           (req.op == OP_ADDR) ? ACT_ADDR : ACT_DATA;
              byte_select <= (req.op == OP_CMD) ? 1'b0 : req.bs;
              data_o    <= (req.op == OP_ADDR && req.bs) ? (req.data & ADDR_HI_MASK)
                                                         : req.data;
              data_oe_n <= 1'b0;
              state_r   <= S_SETUP;
            end
          end
        end
        S_ENT_LO: begin
          if (cnt_r == '0) begin
            reset_hv <= 1'b1;
            cnt_r    <= CNT_W'(SETUP_CYC - 1);
            state_r  <= S_ENT_HV;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_ENT_HV: begin
          // byte_select is left alone for the whole settle window.
          if (cnt_r == '0) begin
            mode_r  <= 1'b1;
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_SETUP: begin
          load_strobe <= 1'b1;
          cnt_r       <= CNT_W'(STROBE_CYC - 1);
          state_r     <= S_LOAD;
        end
        S_LOAD: begin
          if (cnt_r == '0) begin
            load_strobe <= 1'b0;
            cnt_r       <= CNT_W'(STROBE_CYC - 1);
            state_r     <= S_GAP;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_WR_LO: begin
          if (cnt_r == '0) begin
            write_strobe_n <= 1'b1;
            if (is_silent_wr(cmd_r)) begin
              cnt_r   <= CNT_W'(STROBE_CYC - 1);
              state_r <= S_GAP;
            end else begin
              cnt_r   <= CNT_W'(GRACE_CYC - 1);
              state_r <= S_WAIT_LO;
            end
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_WAIT_LO: begin
          // A fast device may never show busy, so the wait is bounded.
          if (!ready_busy_n || cnt_r == '0) begin
            state_r <= S_WAIT_HI;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_WAIT_HI: begin
          if (ready_busy_n) begin
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_RD: begin
          if (cnt_r == '0) begin
            rd_byte_r <= data_i;
            state_r   <= S_PUSH;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_PUSH: begin
          // A full buffer holds the sequencer here until the user drains it.
          if (fifo_in_ready) begin
            output_enable_n <= 1'b1;
            cnt_r           <= CNT_W'(STROBE_CYC - 1);
            state_r         <= S_GAP;
          end
        end
        S_GAP: begin
          if (cnt_r == '0) begin
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Mirror of the device latches
  // ****************************************

  // Tracks what the device holds, since it keeps command and address.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_r     <= '0;
      hi_last_r <= '0;
      hi_ok_r   <= 1'b0;
      dlo_r     <= '0;
      dhi_r     <= '0;
      erased_r  <= 1'b0;
    end else if (accept && req.op == OP_ENTER) begin
      cmd_r    <= '0;
      hi_ok_r  <= 1'b0;
      erased_r <= 1'b0;
    end else if (act_go) begin
      case (req.op)
        OP_CMD: begin
          cmd_r <= req.data;
        end
        OP_ADDR: begin
          if (req.bs) begin
            hi_last_r <= req.data & ADDR_HI_MASK;
            hi_ok_r   <= 1'b1;
          end
        end
        OP_DATA: begin
          if (req.bs) begin
            dhi_r <= req.data;
          end else begin
            dlo_r <= req.data;
          end
        end
        OP_WRITE: begin
          if (cmd_r == CMD_ERASE) begin
            erased_r <= 1'b1;
          end
        end
        default: begin
          erased_r <= erased_r;
        end
      endcase
    end
  end

  // ****************************************
  // Read buffer
  // ****************************************
  ppp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (state_r == S_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_byte_r),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // ****************************************
  // Checks
  // ****************************************

  // Helper counts: cycles of reset and byte_select low, of high voltage, and of write low.
  logic [7:0]       low_cnt_r;
  logic [7:0]       hv_age_r;
  logic [CNT_W-1:0] wlow_cnt_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_r  <= '0;
      hv_age_r   <= '0;
      wlow_cnt_r <= '0;
    end else begin
      low_cnt_r  <= (reset_hv || byte_select) ? '0 :
                    (low_cnt_r == 8'hFF) ? low_cnt_r : low_cnt_r + 1'b1;
      hv_age_r   <= !reset_hv ? '0 : (hv_age_r == 8'hFF) ? hv_age_r : hv_age_r + 1'b1;
      wlow_cnt_r <= write_strobe_n ? '0 : wlow_cnt_r + 1'b1;
    end
  end

  a_entry_low_time: assert property (@(posedge clk) disable iff (!nrst)
    $rose(reset_hv) |-> low_cnt_r >= 8'(SETUP_CYC))
    else $error("High voltage applied too soon after reset low.");

  a_bs_hold_hv: assert property (@(posedge clk) disable iff (!nrst)
    reset_hv && hv_age_r < 8'(SETUP_CYC) |-> $stable(byte_select))
    else $error("byte_select moved while high voltage settled.");

  a_erase_width: assert property (@(posedge clk) disable iff (!nrst)
    $rose(write_strobe_n) && cmd_r == CMD_ERASE |-> wlow_cnt_r == CNT_W'(ERASE_CYC))
    else $error("Erase pulse width wrong.");

  a_erase_first: assert property (@(posedge clk) disable iff (!nrst)
    $fell(write_strobe_n) && is_mem_wr(cmd_r) |-> erased_r)
    else $error("Memory write issued before chip erase.");

  a_addr_hi_mask: assert property (@(posedge clk) disable iff (!nrst)
    $rose(load_strobe) && act_r == ACT_ADDR && byte_select |-> (data_o & ~ADDR_HI_MASK) == '0)
    else $error("Address high byte carries upper bits.");

  a_load_drive: assert property (@(posedge clk) disable iff (!nrst)
    $rose(load_strobe) |-> !data_oe_n && output_enable_n && $stable(data_o) ##1
    load_strobe && $stable(act_r) && $stable(data_o))
    else $error("Pins moved around a load strobe.");

  a_wait_ready: assert property (@(posedge clk) disable iff (!nrst)
    $rose(write_strobe_n) && !is_silent_wr(cmd_r) |-> write_strobe_n throughout
    (state_r == S_WAIT_LO ##[1:8] state_r == S_WAIT_HI))
    else $error("Write sequence did not wait for ready.");

  a_no_bus_fight: assert property (@(posedge clk) disable iff (!nrst)
    !output_enable_n |-> data_oe_n)
    else $error("Controller drives data while device output enabled.");

  a_skip_erased: assert property (@(posedge clk) disable iff (!nrst)
    accept && wr_skip |=> write_strobe_n && done_r)
    else $error("Erased value was written.");

  a_page_reload: assert property (@(posedge clk) disable iff (!nrst)
    accept && mode_r && skip_hi |=> !load_strobe && state_r == S_IDLE)
    else $error("Same page high byte reloaded.");
endmodule

// file: hdl/ppp_pkg.sv
// Constants, types and pin codes for the parallel programming port controller.
package ppp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ    = 200;
  localparam int SETUP_NS   = 100;
  localparam int SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_NS  = 50;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_NS    = 50;
  localparam int READ_CYC   = (READ_NS * CLK_MHZ + 999) / 1000;
  localparam int GRACE_CYC  = 8;
  localparam int ERASE_US   = 10000;

  // ****************************************
  // Pin codes and command bytes
  // ****************************************
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_FUSE_WR  = 8'h40;
  localparam logic [7:0] CMD_LOCK_WR  = 8'h20;
  localparam logic [7:0] CMD_FLASH_WR = 8'h10;
  localparam logic [7:0] CMD_EE_WR    = 8'h11;
  localparam logic [7:0] CMD_SIG_RD   = 8'h08;
  localparam logic [7:0] CMD_FL_RD    = 8'h04;
  localparam logic [7:0] CMD_FLASH_RD = 8'h02;
  localparam logic [7:0] CMD_EE_RD    = 8'h03;
  localparam logic [7:0] ADDR_HI_MASK = 8'h03;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    OP_ENTER = 3'h0,
    OP_CMD   = 3'h1,
    OP_ADDR  = 3'h2,
    OP_DATA  = 3'h3,
    OP_WRITE = 3'h4,
    OP_READ  = 3'h5,
    OP_EXIT  = 3'h6,
    OP_NOP   = 3'h7
  } ppp_op_t;

  typedef struct packed {
    ppp_op_t    op;
    logic       bs;
    logic [7:0] data;
  } ppp_req_t;

endpackage

// file: verif/ppp_dev_model.sv
// Behavioural model of the target device seen through its programming pins.
`timescale 1ns/1ps
module ppp_dev_model
  import ppp_pkg::*;
#(
  parameter real        ERASE_PW_NS = 1000.0,
  parameter logic [7:0] SIG_2       = 8'h7E  // Arbitrary value.
) (
  // Clock for the floating bus pattern
  input  wire logic       clk,
  // Device pins
  input  wire logic       reset_hv,
  input  wire logic       load_strobe,
  input  wire logic       xtal_action_1,
  input  wire logic       xtal_action_0,
  input  wire logic       byte_select,
  input  wire logic       write_strobe_n,
  input  wire logic       output_enable_n,
  input  wire logic [7:0] data_o,
  input  wire logic       data_oe_n,
  output logic [7:0]      data_i,
  output logic            ready_busy_n
);
  // ****************
  // Device state
  // ****************
  logic [15:0] flash [1024];
  logic [7:0]  ee [128];
  logic [7:0]  fuse, lock, cmd, a_hi, a_lo, d_lo, d_hi, rd_byte, last;
  logic [9:0]  addr;
  logic        in_mode;
  real         t_rlo, t_hv, t_bs, t_wr;
  int          viol, wr_n;
  int          busy_ns = 20;

  // Memories start non-blank so that an erase is visible.
  initial begin
    for (int i = 0; i < 1024; i++) flash[i] = 16'h0000;
    for (int i = 0; i < 128; i++) ee[i] = 8'h00;
    {fuse, lock, cmd, in_mode, viol, wr_n} = {8'hDF, 8'h00, 8'h00, 1'b0, 32'h0, 32'h0};
    t_rlo = 0.0;
    t_hv  = 0.0;
    t_bs  = 0.0;
    t_wr  = 0.0;
    ready_busy_n = 1'b1;
  end

  // A released bus shows the inverse of its last level, never a stale copy.
  assign data_i = !data_oe_n ? data_o : !output_enable_n ? rd_byte : ~last;
  assign addr   = {a_hi[1:0], a_lo};
  always @(posedge clk) last <= data_i;

  // Mode entry needs 100 ns of low reset and steady byte select around the rise.
  always @(negedge reset_hv) begin
    in_mode = 1'b0;
    t_rlo   = $realtime;
  end
  always @(posedge reset_hv) begin
    in_mode = !byte_select && ($realtime - t_rlo >= 100.0) && ($realtime - t_bs >= 100.0);
    t_hv    = $realtime;
  end
  always @(byte_select) begin
    if (reset_hv && $realtime - t_hv < 100.0) in_mode = 1'b0;
    t_bs = $realtime;
  end

  // Latches capture on the rising load edge only.
  always @(posedge load_strobe) begin
    if (in_mode) begin
      case ({xtal_action_1, xtal_action_0})
        ACT_ADDR: if (byte_select) a_hi = data_i; else a_lo = data_i;
        ACT_DATA: if (byte_select) d_hi = data_i; else d_lo = data_i;
        ACT_CMD:  cmd = data_i;
        default:  ;
      endcase
    end
  end

  // A write started while busy is counted as a fault of the programmer.
  always @(negedge write_strobe_n) begin
    if (!ready_busy_n) viol++;
  end

  // Byte writes start on the falling strobe and hold busy for busy_ns.
  always @(negedge write_strobe_n) begin
    t_wr = $realtime;
    if (in_mode && (cmd == CMD_FLASH_WR || cmd == CMD_EE_WR || cmd == CMD_LOCK_WR)) begin
      if (cmd == CMD_EE_WR) ee[addr[6:0]] = d_lo;
      else if (cmd == CMD_LOCK_WR) lock = lock & d_lo;
      else if (byte_select) flash[addr][15:8] = d_hi;
      else flash[addr][7:0] = d_lo;
      wr_n++;
      ready_busy_n <= 1'b0;
      #(busy_ns) ready_busy_n <= 1'b1;
    end
  end

  // Erase acts only after a wide enough pulse; lock bits go last, fuses stay.
  always @(posedge write_strobe_n) begin
    if (in_mode && cmd == CMD_ERASE && $realtime - t_wr >= ERASE_PW_NS) begin
      for (int i = 0; i < 1024; i++) flash[i] = 16'hFFFF;
      for (int i = 0; i < 128; i++) ee[i] = 8'hFF;
      lock = 8'hFF;
    end
    if (in_mode && cmd == CMD_FUSE_WR) fuse = d_lo;
  end

  // Read data follows the latched command.
  always_comb begin
    case (cmd)
      CMD_FLASH_RD: rd_byte = byte_select ? flash[addr][15:8] : flash[addr][7:0];
      CMD_EE_RD:    rd_byte = ee[addr[6:0]];
      CMD_SIG_RD:   rd_byte = SIG_2;
      CMD_FL_RD:    rd_byte = byte_select ? lock : fuse;
      default:      rd_byte = 8'h00;
    endcase
  end
endmodule

// file: verif/test_ppp_host.sv
// Self-checking bench for the parallel programming port controller.
`timescale 1ns/1ps
module test_ppp_host;
  import ppp_pkg::*;
  // ****************
  // Signals
  // ****************
  localparam logic [7:0] SIG_2 = 8'h5C;  // Arbitrary signature value.
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       req_valid = 1'b0;
  logic       rd_ready = 1'b1;
  ppp_req_t   req = '0;
  logic       req_ready, done, refused, prog_mode, rd_valid, reset_hv, load_strobe;
  logic       xtal_action_1, xtal_action_0, byte_select, write_strobe_n, output_enable_n;
  logic       data_oe_n, ready_busy_n;
  logic [7:0] rd_data, data_o, data_i;
  logic [7:0] rq [$];
  int         bad_count = 0;
  int         n_tests = 0;
  int         n_loads = 0;
  int         k = 0;

  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;

  // Load pulses seen by the device, to prove that a same-page reload is dropped.
  always @(posedge load_strobe) n_loads++;

  ppp_host #(.ERASE_US_P(1)) ppp_host_inst (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .done(done), .refused(refused), .prog_mode(prog_mode),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .reset_hv(reset_hv),
    .load_strobe(load_strobe), .xtal_action_1(xtal_action_1), .xtal_action_0(xtal_action_0),
    .byte_select(byte_select), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .data_o(data_o), .data_oe_n(data_oe_n),
    .data_i(data_i), .ready_busy_n(ready_busy_n));
  ppp_dev_model #(.SIG_2(SIG_2)) ppp_dev_model_inst (.clk(clk), .reset_hv(reset_hv),
    .load_strobe(load_strobe), .xtal_action_1(xtal_action_1), .xtal_action_0(xtal_action_0),
    .byte_select(byte_select), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .data_o(data_o), .data_oe_n(data_oe_n),
    .data_i(data_i), .ready_busy_n(ready_busy_n));

  // Popped bytes are taken with the values of the popping edge.
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && rd_ready) rq.push_back(rd_data);
  end

  // Both sides driving the bus at once would be a short.
  always @(negedge clk) begin
    if (output_enable_n === 1'b0) cmp_flag(data_oe_n, 1'b1);
  end

  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatched", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask

  // One request: held until taken, then the refusal flag is checked with done.
  task automatic do_req(input ppp_op_t o, input logic hi, input logic [7:0] d, input logic rf);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    req <= '{o, hi, d};
    req_valid <= 1'b1;
    while (!got && n < 60000) begin
      @(negedge clk);
      got = (req_ready === 1'b1);
      @(posedge clk);
      n++;
    end
    req_valid <= 1'b0;
    got = 1'b0;
    while (!got && n < 60000) begin
      @(negedge clk);
      got = (done === 1'b1);
      n++;
      if (got) cmp_flag(refused, rf);
      @(posedge clk);
    end
    if (n >= 60000) begin
      bad_count++;
      close_out();
    end
  endtask

  task automatic rd_chk(input logic [7:0] exp);
    int n;
    n = 0;
    while (rq.size() == 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (rq.size() == 0) begin
      bad_count++;
      close_out();
    end else begin
      cmp_byte(rq.pop_front(), exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("End of %s: %0d mismatches so far", name, bad_count);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    do_req(OP_CMD, 1'b0, CMD_SIG_RD, 1'b1);
    do_req(OP_ENTER, 1'b0, 8'h00, 1'b0);
    cmp_flag(ppp_dev_model_inst.in_mode, 1'b1);
    cmp_flag(prog_mode, 1'b1);
    do_req(OP_NOP, 1'b0, 8'h00, 1'b1);
    do_req(OP_CMD, 1'b0, CMD_FLASH_WR, 1'b0);
    do_req(OP_WRITE, 1'b0, 8'h00, 1'b1);
    end_test("entry");
    do_req(OP_CMD, 1'b0, CMD_ERASE, 1'b0);
    do_req(OP_WRITE, 1'b0, 8'h00, 1'b0);
    cmp_byte(ppp_dev_model_inst.flash[5][7:0], ERASED_BYTE);
    cmp_byte(ppp_dev_model_inst.ee[5], ERASED_BYTE);
    cmp_byte(ppp_dev_model_inst.lock, 8'hFF);
    cmp_byte(ppp_dev_model_inst.fuse, 8'hDF);
    end_test("erase");
    do_req(OP_CMD, 1'b0, CMD_FLASH_WR, 1'b0);
    do_req(OP_ADDR, 1'b1, 8'h07, 1'b0);
    cmp_byte(ppp_dev_model_inst.a_hi, 8'h03);
    do_req(OP_ADDR, 1'b0, 8'h5A, 1'b0);
    do_req(OP_DATA, 1'b0, 8'h34, 1'b0);
    do_req(OP_DATA, 1'b1, 8'h12, 1'b0);
    do_req(OP_WRITE, 1'b0, 8'h00, 1'b0);
    do_req(OP_WRITE, 1'b1, 8'h00, 1'b0);
    cmp_byte(ppp_dev_model_inst.flash[10'h35A][15:8], 8'h12);
    cmp_byte(ppp_dev_model_inst.flash[10'h35A][7:0], 8'h34);
    ppp_dev_model_inst.busy_ns = 400;
    do_req(OP_ADDR, 1'b0, 8'h5B, 1'b0);
    do_req(OP_DATA, 1'b0, ERASED_BYTE, 1'b0);
    do_req(OP_WRITE, 1'b0, 8'h00, 1'b0);
    cmp_byte(ppp_dev_model_inst.wr_n[7:0], 8'h02);
    do_req(OP_DATA, 1'b0, 8'h77, 1'b0);
    do_req(OP_WRITE, 1'b0, 8'h00, 1'b0);
    cmp_flag(ready_busy_n, 1'b1);
    cmp_byte(ppp_dev_model_inst.viol[7:0], 8'h00);
    end_test("flash write");
    k = n_loads;
    do_req(OP_ADDR, 1'b1, 8'h07, 1'b0);
    cmp_byte(8'(n_loads - k), 8'h00);
    do_req(OP_CMD, 1'b0, CMD_FLASH_RD, 1'b0);
    do_req(OP_ADDR, 1'b0, 8'h5A, 1'b0);
    do_req(OP_READ, 1'b0, 8'h00, 1'b0);
    do_req(OP_READ, 1'b1, 8'h00, 1'b0);
    rd_chk(8'h34);
    rd_chk(8'h12);
    do_req(OP_CMD, 1'b0, CMD_EE_WR, 1'b0);
    do_req(OP_ADDR, 1'b0, 8'h10, 1'b0);
    do_req(OP_DATA, 1'b0, 8'hA5, 1'b0);
    do_req(OP_WRITE, 1'b0, 8'h00, 1'b0);
    do_req(OP_CMD, 1'b0, CMD_EE_RD, 1'b0);
    do_req(OP_READ, 1'b0, 8'h00, 1'b0);
    rd_chk(8'hA5);
    do_req(OP_CMD, 1'b0, CMD_LOCK_WR, 1'b0);
    do_req(OP_DATA, 1'b0, 8'hF9, 1'b0);
    do_req(OP_WRITE, 1'b0, 8'h00, 1'b0);
    do_req(OP_CMD, 1'b0, CMD_FUSE_WR, 1'b0);
    do_req(OP_DATA, 1'b0, 8'hDE, 1'b0);
    do_req(OP_WRITE, 1'b0, 8'h00, 1'b0);
    do_req(OP_CMD, 1'b0, CMD_FL_RD, 1'b0);
    do_req(OP_READ, 1'b0, 8'h00, 1'b0);
    do_req(OP_READ, 1'b1, 8'h00, 1'b0);
    rd_chk(8'hDE);
    rd_chk(8'hF9);
    end_test("reads");
    do_req(OP_CMD, 1'b0, CMD_SIG_RD, 1'b0);
    rd_ready <= 1'b0;
    for (int i = 0; i < 4; i++) do_req(OP_READ, 1'b0, 8'h00, 1'b0);
    fork
      do_req(OP_READ, 1'b0, 8'h00, 1'b0);
      begin
        repeat (80) @(negedge clk);
        cmp_flag(req_ready, 1'b0);
        cmp_flag(rd_valid, 1'b1);
        @(posedge clk);
        rd_ready <= 1'b1;
      end
    join
    for (int i = 0; i < 5; i++) rd_chk(SIG_2);
    end_test("fifo stall");
    do_req(OP_EXIT, 1'b0, 8'h00, 1'b0);
    cmp_flag(prog_mode, 1'b0);
    cmp_flag(ppp_dev_model_inst.in_mode, 1'b0);
    do_req(OP_READ, 1'b0, 8'h00, 1'b1);
    end_test("exit");
    close_out();
  end
endmodule
